// ---- dv/pin_irq_status_sva.sv ----
`timescale 1ns/1ps
// ****
// Port checks.
// ****
module pin_irq_status_sva (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  // Flags.
  input wire [22:0] pin_pending_q,
  input wire port_summary_q
);
  wire [22:0] clr_m = (reg_wr && reg_addr == 8'h14) ? reg_wdata[22:0] : 23'h000000;
  wire sum_clr = reg_wr && reg_addr == 8'h18 && reg_wdata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_upper_zero: assert property (reg_rd |=> reg_rdata_q[31:23] == 9'h000) else $error("upper bits");
  a_status_map: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata_q[22:0] == $past(pin_pending_q))
    else $error("status map");
  a_clear_zero: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata_q == 32'h00000000) else $error("clear");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 32'h00000000) else $error("idle read");
  a_clear_only: assert property (($past(pin_pending_q) & ~pin_pending_q & ~$past(clr_m)) == 23'h000000)
    else $error("lost flag");
  a_summary_on: assert property (|pin_pending_q |-> port_summary_q) else $error("summary off");
  a_summary_hold: assert property (port_summary_q && !sum_clr |=> port_summary_q) else $error("summary drop");
  a_summary_clr: assert property (sum_clr && pin_pending_q == 23'h000000 |=> !port_summary_q || |pin_pending_q)
    else $error("summary stuck");
endmodule // pin_irq_status_sva
bind pin_irq_status pin_irq_status_sva i_pin_irq_status_sva (
  .clk(clk),
  .arst_n(arst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q),
  .pin_pending_q(pin_pending_q),
  .port_summary_q(port_summary_q)
);

// ---- dv/pin_irq_status_test.sv ----
`timescale 1ns/1ps
module pin_irq_status_test;
  // ****
  // Register scenarios.
  // ****
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [22:0] want = 23'h0;
  wire [31:0] reg_rdata_q;
  wire [2:0] video_ctrl_pins;
  wire [19:0] video_data_pins;
  wire [22:0] pin_pending_q;
  wire port_summary_q;
  int fail_count = 0, checks_done = 0;
  pin_irq_status i_pin_irq_status (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .video_ctrl_pins(video_ctrl_pins),
    .video_data_pins(video_data_pins),
    .pin_pending_q(pin_pending_q),
    .port_summary_q(port_summary_q)
  );
  pin_toggler i_pin_toggler (
    .clk(clk),
    .want(want),
    .video_ctrl_pins(video_ctrl_pins),
    .video_data_pins(video_data_pins)
  );
  task automatic chk(string nm, logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), reg_rdata_q, e);
  endtask
  task automatic drive(logic [22:0] v);
    @(posedge clk) want <= v;
    repeat (8) @(posedge clk);
  endtask
  task close_out;
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  initial begin
    #20000 fail_count++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h10, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    wr(8'h04, 32'hFFFFFFFF);
    wr(8'h08, 32'hFFFFFFFF);
    wr(8'h0C, 32'h00555555);
    drive(23'h7FFFFF);
    rd(8'h10, 32'h002AAAAA);
    chk("summary", {31'h0, port_summary_q}, 32'h1);
    wr(8'h14, 32'hFF0000AA);
    rd(8'h14, 32'h0);
    rd(8'h10, 32'h002AAA00);
    wr(8'h10, 32'h0);
    drive(23'h000000);
    rd(8'h10, 32'h007FFF55);
    wr(8'h18, 32'h1);
    rd(8'h18, 32'h1);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    rd(8'h18, 32'h1);
    wr(8'h18, 32'h1);
    rd(8'h18, 32'h0);
    wr(8'h00, 32'h00700000);
    drive(23'h7FFFFF);
    rd(8'h10, 32'h00200000);
    drive(23'h000000);
    @(posedge clk) want <= 23'h7FFFFF;
    repeat (4) @(posedge clk);
    wr(8'h14, 32'h00700000);
    rd(8'h10, 32'h00200000);
    wr(8'h04, 32'h005FFFFF);
    wr(8'h08, 32'h003FFFFF);
    wr(8'h14, 32'hFFFFFFFF);
    drive(23'h000000);
    drive(23'h7FFFFF);
    rd(8'h10, 32'h00100000);
    chk("pending", {9'h000, pin_pending_q}, 32'h00100000);
    close_out;
  end
endmodule // pin_irq_status_test

// ---- dv/pin_toggler.sv ----
`timescale 1ns/1ps
// ****
// External pin driver.
// ****
module pin_toggler (
  input wire clk,
  input wire [22:0] want,
  output logic [2:0] video_ctrl_pins = 3'h0,
  output logic [19:0] video_data_pins = 20'h00000
);
  always @(posedge clk) {video_ctrl_pins, video_data_pins} <= want;
endmodule // pin_toggler

// ---- hdl/pin_irq_defines.vh ----
`ifndef PIN_IRQ_DEFINES_VH
`define PIN_IRQ_DEFINES_VH
// ****************************************************************
// Register offsets.
// ****************************************************************
`define PIN_IRQ_ENABLE_OFFSET 8'h00
`define PIN_FUNCTION_SELECT_OFFSET 8'h04
`define PIN_DIRECTION_OFFSET 8'h08
`define PIN_EDGE_POLARITY_OFFSET 8'h0C
`define PIN_PENDING_FLAGS_OFFSET 8'h10
`define PIN_PENDING_CLEAR_OFFSET 8'h14
`define PORT_IRQ_STATUS_OFFSET 8'h18
// ****************************************************************
// Field layout and reset values.
// ****************************************************************
`define PIN_COUNT 23
`define PIN_MSB 22
`define DATA_PIN_MSB 19
`define CTRL_PIN_LSB 20
`define SUMMARY_BIT 0
`define PIN_REG_RESET 23'h000000
`define READ_ZERO 32'h00000000
`endif

// ---- hdl/pin_irq_status.v ----
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "pin_irq_defines.vh"
module pin_irq_status (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // Pins.
  input wire [2:0] video_ctrl_pins,
  input wire [19:0] video_data_pins,
  // Status outputs.
  output reg [22:0] pin_pending_q,
  output reg port_summary_q
);
  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  reg [22:0] irq_enable_q;
  reg [22:0] irq_enable_d;
  reg [22:0] function_sel_q;
  reg [22:0] function_sel_d;
  reg [22:0] direction_q;
  reg [22:0] direction_d;
  reg [22:0] polarity_q;
  reg [22:0] polarity_d;

  wire sel_enable;
  wire sel_function;
  wire sel_direction;
  wire sel_polarity;
  wire sel_flags;
  wire sel_clear;
  wire sel_summary;
  wire wr_enable;
  wire wr_function;
  wire wr_direction;
  wire wr_polarity;
  wire wr_clear;
  wire wr_summary;

  wire [22:0] raw_pins;
  wire [22:0] pin_level;
  reg [22:0] prev_level_q;
  wire [22:0] hit;
  wire [2:0] clr_ctrl;
  wire [19:0] clr_data;
  wire [22:0] clr_mask;
  wire [22:0] pending_d;

  wire any_hit;
  wire any_left;
  wire summary_set;
  wire summary_clr;
  reg summary_d;

  wire [2:0] ctrl_pending;
  wire [19:0] data_pending;
  wire [31:0] enable_word;
  wire [31:0] function_word;
  wire [31:0] direction_word;
  wire [31:0] polarity_word;
  wire [31:0] flags_word;
  wire [31:0] clear_word;
  wire [31:0] summary_word;
  reg [31:0] rd_word;
  reg [31:0] rdata_d;
  genvar gi;

  // ****************************************************************
  // Register decode.
  // ****************************************************************
  assign sel_enable = (reg_addr == `PIN_IRQ_ENABLE_OFFSET);
  assign sel_function = (reg_addr == `PIN_FUNCTION_SELECT_OFFSET);
  assign sel_direction = (reg_addr == `PIN_DIRECTION_OFFSET);
  assign sel_polarity = (reg_addr == `PIN_EDGE_POLARITY_OFFSET);
  assign sel_flags = (reg_addr == `PIN_PENDING_FLAGS_OFFSET);
  assign sel_clear = (reg_addr == `PIN_PENDING_CLEAR_OFFSET);
  assign sel_summary = (reg_addr == `PORT_IRQ_STATUS_OFFSET);

  assign wr_enable = reg_wr & sel_enable;
  assign wr_function = reg_wr & sel_function;
  assign wr_direction = reg_wr & sel_direction;
  assign wr_polarity = reg_wr & sel_polarity;
  assign wr_clear = reg_wr & sel_clear;
  assign wr_summary = reg_wr & sel_summary & reg_wdata[`SUMMARY_BIT];

  // ****************************************************************
  // Configuration next values.
  // ****************************************************************
  always @* begin
    irq_enable_d = irq_enable_q;
    if (wr_enable) begin
      irq_enable_d = reg_wdata[`PIN_MSB:0];
    end
  end

  always @* begin
    function_sel_d = function_sel_q;
    if (wr_function) begin
      function_sel_d = reg_wdata[`PIN_MSB:0];
    end
  end

  always @* begin
    direction_d = direction_q;
    if (wr_direction) begin
      direction_d = reg_wdata[`PIN_MSB:0];
    end
  end

  always @* begin
    polarity_d = polarity_q;
    if (wr_polarity) begin
      polarity_d = reg_wdata[`PIN_MSB:0];
    end
  end

  // ****************************************************************
  // Configuration flip-flops.
  // ****************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable_q <= `PIN_REG_RESET;
    end else begin
      irq_enable_q <= irq_enable_d;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      function_sel_q <= `PIN_REG_RESET;
    end else begin
      function_sel_q <= function_sel_d;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      direction_q <= `PIN_REG_RESET;
    end else begin
      direction_q <= direction_d;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      polarity_q <= `PIN_REG_RESET;
    end else begin
      polarity_q <= polarity_d;
    end
  end

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  assign raw_pins = {video_ctrl_pins, video_data_pins};
  pin_sync3 u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin_raw(raw_pins),
    .pin_level_q(pin_level)
  );

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_level_q <= `PIN_REG_RESET;
    end else begin
      prev_level_q <= pin_level;
    end
  end

  // ****************************************************************
  // Clear mask.
  // ****************************************************************
  assign clr_ctrl = reg_wdata[`PIN_MSB:`CTRL_PIN_LSB];
  assign clr_data = reg_wdata[`DATA_PIN_MSB:0];
  assign clr_mask = wr_clear ? {clr_ctrl, clr_data} : `PIN_REG_RESET;

  // ****************************************************************
  // Per-pin edge detection and pending flags.
  // ****************************************************************
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pin
      wire armed;
      wire rise;
      wire fall;
      wire trig;
      wire clr;
      // Direction bit one means input.
      assign armed = irq_enable_q[gi] & function_sel_q[gi] & direction_q[gi];
      assign rise = pin_level[gi] & ~prev_level_q[gi];
      assign fall = ~pin_level[gi] & prev_level_q[gi];
      assign trig = polarity_q[gi] ? fall : rise;
      assign clr = clr_mask[gi];
      assign hit[gi] = armed & trig;
      assign pending_d[gi] = hit[gi] | (pin_pending_q[gi] & ~clr);
    end
  endgenerate

  // ****************************************************************
  // Pending flag flip-flops.
  // ****************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_pending_q <= `PIN_REG_RESET;
    end else begin
      pin_pending_q <= pending_d;
    end
  end

  // ****************************************************************
  // Port summary flag.
  // ****************************************************************
  assign any_hit = |hit;
  assign any_left = |pending_d;
  assign summary_set = any_hit | (wr_summary & any_left);
  assign summary_clr = wr_summary;

  always @* begin
    summary_d = port_summary_q;
    if (summary_clr) begin
      summary_d = 1'h0;
    end
    if (summary_set) begin
      summary_d = 1'h1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_summary_q <= 1'h0;
    end else begin
      port_summary_q <= summary_d;
    end
  end

  // ****************************************************************
  // Read data.
  // ****************************************************************
  assign ctrl_pending = pin_pending_q[`PIN_MSB:`CTRL_PIN_LSB];
  assign data_pending = pin_pending_q[`DATA_PIN_MSB:0];
  assign enable_word = {9'h000, irq_enable_q};
  assign function_word = {9'h000, function_sel_q};
  assign direction_word = {9'h000, direction_q};
  assign polarity_word = {9'h000, polarity_q};
  assign flags_word = {9'h000, ctrl_pending, data_pending};
  assign clear_word = `READ_ZERO;
  assign summary_word = {31'h00000000, port_summary_q};

  always @* begin
    rd_word = `READ_ZERO;
    if (sel_enable) begin
      rd_word = enable_word;
    end
    if (sel_function) begin
      rd_word = function_word;
    end
    if (sel_direction) begin
      rd_word = direction_word;
    end
    if (sel_polarity) begin
      rd_word = polarity_word;
    end
    if (sel_flags) begin
      rd_word = flags_word;
    end
    if (sel_clear) begin
      rd_word = clear_word;
    end
    if (sel_summary) begin
      rd_word = summary_word;
    end
  end

  always @* begin
    rdata_d = `READ_ZERO;
    if (reg_rd) begin
      rdata_d = rd_word;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= `READ_ZERO;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end
endmodule // pin_irq_status

// ---- hdl/pin_sync3.v ----
`timescale 1ns/1ps
`include "pin_irq_defines.vh"
module pin_sync3 (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Raw pins and filtered levels.
  input wire [22:0] pin_raw,
  output reg [22:0] pin_level_q
);
  reg [22:0] meta_q;
  reg [22:0] s2_q;
  reg [22:0] s3_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= `PIN_REG_RESET;
      s2_q <= `PIN_REG_RESET;
      s3_q <= `PIN_REG_RESET;
      pin_level_q <= `PIN_REG_RESET;
    end else begin
      meta_q <= pin_raw;
      s2_q <= meta_q;
      s3_q <= s2_q;
      pin_level_q <= (s2_q & s3_q) | (pin_level_q & (s2_q | s3_q));
    end
  end
endmodule // pin_sync3
